//--- eei_top.sv
// two-wire serial memory slave: byte write, current read, write cycle
`timescale 1ns/1ps
`include "eei_consts.svh"
`default_nettype none
module eei_top
  import eei_pkg::*;
#(
  parameter int unsigned ARR_BITS  = `EEI_ARR_BITS_DEF,
  parameter int unsigned WR_CYCLES = `EEI_WR_CYCLES,
  parameter int unsigned PU_CYCLES = `EEI_PU_CYCLES
) (
  input  wire logic REF_CLK,
  input  wire logic RST_N,
  input  wire logic SCL,
  input  wire logic SDA_I,
  output var  logic SDA_O,
  output var  logic SDA_OE,
  input  wire logic SELECT_PIN_BIT0,
  input  wire logic SELECT_PIN_BIT1,
  input  wire logic SELECT_PIN_BIT2,
  input  wire logic WRITE_PROTECT,
  input  wire logic POWER_GOOD,
  output var  logic BUSY,
  output var  logic READY
);
  localparam int unsigned AW = 8 + ARR_BITS;
  localparam logic [2:0] SEL_MASK = 3'(3'h7 << ARR_BITS);

  eei_pins_t   pin_raw;
  eei_pins_t   pin_s;
  eei_bus_ev_t ev;

  logic        scl_p_q;
  logic        scl_p_d;
  logic        sda_p_q;
  logic        sda_p_d;
  logic [7:0]  link_shift_q;
  logic [7:0]  link_shift_d;
  logic [7:0]  mem_rd;
  logic [7:0]  rx_byte;
  logic        addr_match;
  logic [10:0] full_addr;

  eei_state_t    state_q;
  eei_state_t    state_d;
  eei_state_t    ret_q;
  eei_state_t    ret_d;
  logic [3:0]    cnt_q;
  logic [3:0]    cnt_d;
  logic          oe_q;
  logic          oe_d;
  logic [7:0]    tx_q;
  logic [7:0]    tx_d;
  logic [AW-1:0] ptr_q;
  logic [AW-1:0] ptr_d;
  logic [AW-1:0] waddr_q;
  logic [AW-1:0] waddr_d;
  logic [7:0]    wdata_q;
  logic [7:0]    wdata_d;
  logic          pend_q;
  logic          pend_d;
  logic          wp_blk_q;
  logic          wp_blk_d;
  logic          mack_q;
  logic          mack_d;
  logic [2:0]    upper_q;
  logic [2:0]    upper_d;
  logic [31:0]   timer_q;
  logic [31:0]   timer_d;
  logic          we_q;
  logic          we_d;
  logic          busy_q;
  logic          busy_d;
  logic          ready_q;
  logic          ready_d;

  assign pin_raw.scl = SCL;
  assign pin_raw.sda = SDA_I;
  assign pin_raw.wp  = WRITE_PROTECT;
  assign pin_raw.pg  = POWER_GOOD;
  assign pin_raw.sel = {SELECT_PIN_BIT2, SELECT_PIN_BIT1, SELECT_PIN_BIT0};

  // pin levels enter the reference domain through two flops
  eei_sync #(
    .W ($bits(eei_pins_t))
  ) u_sync (
    .clk (REF_CLK),
    .d   (pin_raw),
    .q   (pin_s)
  );

  // link domain: data captured on the rising serial clock
  always_comb begin
    link_shift_d = {link_shift_q[6:0], SDA_I};
  end

  always_ff @(posedge SCL) begin
    link_shift_q <= link_shift_d;
  end

  // the link shifter is read only after a synchronised clock fall, when
  // it cannot move again before the next rise, a full low period away
  assign rx_byte = link_shift_q;

  eei_mem #(
    .AW (AW)
  ) u_mem (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .we    (we_q),
    .waddr (waddr_q),
    .wdata (wdata_q),
    .raddr (ptr_q),
    .rdata (mem_rd)
  );

  always_comb begin
    scl_p_d  = pin_s.scl;
    sda_p_d  = pin_s.sda;
    ev.start = pin_s.scl & scl_p_q & sda_p_q & ~pin_s.sda;
    ev.stop  = pin_s.scl & scl_p_q & ~sda_p_q & pin_s.sda;
    ev.rise  = pin_s.scl & ~scl_p_q;
    ev.fall  = ~pin_s.scl & scl_p_q;
  end

  always_comb begin
    addr_match = (rx_byte[`EEI_TYPE_MSB:`EEI_TYPE_LSB] == `EEI_TYPE_CODE)
      && (((rx_byte[`EEI_SEL_MSB:`EEI_SEL_LSB] ^ pin_s.sel) & SEL_MASK)
          == 3'h0);
    full_addr = {upper_q, rx_byte};
  end

  always_comb begin
    state_d  = state_q;
    ret_d    = ret_q;
    cnt_d    = cnt_q;
    oe_d     = oe_q;
    tx_d     = tx_q;
    ptr_d    = ptr_q;
    waddr_d  = waddr_q;
    wdata_d  = wdata_q;
    pend_d   = pend_q;
    wp_blk_d = wp_blk_q;
    mack_d   = mack_q;
    upper_d  = upper_q;
    timer_d  = timer_q;
    we_d     = 1'b0;
    if (!pin_s.pg) begin
      state_d = ST_PWRUP;
      timer_d = 32'h0;
      oe_d    = 1'b0;
      pend_d  = 1'b0;
    end else if (state_q == ST_PWRUP) begin
      timer_d = timer_q + 32'h1;
      if (timer_q >= PU_CYCLES - 1) begin
        state_d = ST_IDLE;
        timer_d = 32'h0;
      end
    end else if (state_q == ST_BUSY) begin
      oe_d    = 1'b0;
      timer_d = timer_q + 32'h1;
      if (timer_q >= WR_CYCLES - 1) begin
        state_d = ST_IDLE;
        timer_d = 32'h0;
      end
    end else if (ev.start) begin
      state_d  = ST_ADDR;
      cnt_d    = 4'h0;
      oe_d     = 1'b0;
      pend_d   = 1'b0;
      wp_blk_d = 1'b0;
    end else if (ev.stop) begin
      oe_d  = 1'b0;
      cnt_d = 4'h0;
      if (pend_q) begin
        we_d    = 1'b1;
        pend_d  = 1'b0;
        ptr_d   = AW'(waddr_q + 1'b1);
        state_d = ST_BUSY;
        timer_d = 32'h0;
      end else begin
        state_d = ST_IDLE;
      end
    end else begin
      unique case (state_q)
        ST_ADDR, ST_WADDR, ST_WDATA: begin
          if (ev.rise) begin
            cnt_d = cnt_q + 4'h1;
          end
          if (ev.fall && cnt_q == `EEI_BYTE_BITS) begin
            cnt_d = 4'h0;
            if (state_q == ST_ADDR) begin
              if (addr_match) begin
                oe_d    = 1'b1;
                upper_d = rx_byte[`EEI_SEL_MSB:`EEI_SEL_LSB];
                ret_d   = rx_byte[`EEI_RW_POS] ? ST_TX : ST_WADDR;
                state_d = ST_ACK;
              end else begin
                state_d = ST_IGNORE;
              end
            end else if (state_q == ST_WADDR) begin
              waddr_d = full_addr[AW-1:0];
              ptr_d   = full_addr[AW-1:0];
              oe_d    = 1'b1;
              ret_d   = ST_WDATA;
              state_d = ST_ACK;
            end else if (!wp_blk_q) begin
              wdata_d = rx_byte;
              pend_d  = 1'b1;
              oe_d    = 1'b1;
              ret_d   = ST_IGNORE;
              state_d = ST_ACK;
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        ST_ACK: begin
          if (ev.fall) begin
            if (ret_q == ST_WDATA) begin
              wp_blk_d = pin_s.wp;
            end
            if (ret_q == ST_TX) begin
              tx_d    = mem_rd;
              oe_d    = ~mem_rd[7];
              cnt_d   = 4'h1;
              state_d = ST_TX;
            end else begin
              oe_d    = 1'b0;
              cnt_d   = 4'h0;
              state_d = ret_q;
            end
          end
        end
        ST_TX: begin
          if (ev.fall) begin
            if (cnt_q == `EEI_BYTE_BITS) begin
              oe_d    = 1'b0;
              ptr_d   = AW'(ptr_q + 1'b1);
              cnt_d   = 4'h0;
              state_d = ST_RXACK;
            end else begin
              tx_d  = {tx_q[6:0], 1'b0};
              oe_d  = ~tx_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_RXACK: begin
          if (ev.rise) begin
            mack_d = ~pin_s.sda;
          end
          if (ev.fall) begin
            if (mack_q) begin
              tx_d    = mem_rd;
              oe_d    = ~mem_rd[7];
              cnt_d   = 4'h1;
              state_d = ST_TX;
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          oe_d = 1'b0;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
    busy_d  = (state_d == ST_BUSY);
    ready_d = (state_d != ST_PWRUP);
  end

  // reset holds the power-up state; the slave never drives high
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
      state_q  <= ST_PWRUP;
      ret_q    <= ST_IDLE;
      cnt_q    <= 4'h0;
      oe_q     <= 1'b0;
      tx_q     <= 8'h00;
      ptr_q    <= '0;
      waddr_q  <= '0;
      wdata_q  <= 8'h00;
      pend_q   <= 1'b0;
      wp_blk_q <= 1'b0;
      mack_q   <= 1'b0;
      upper_q  <= 3'h0;
      timer_q  <= 32'h0;
      we_q     <= 1'b0;
      busy_q   <= 1'b0;
      ready_q  <= 1'b0;
      SDA_O    <= 1'b0;
    end else begin
      scl_p_q  <= scl_p_d;
      sda_p_q  <= sda_p_d;
      state_q  <= state_d;
      ret_q    <= ret_d;
      cnt_q    <= cnt_d;
      oe_q     <= oe_d;
      tx_q     <= tx_d;
      ptr_q    <= ptr_d;
      waddr_q  <= waddr_d;
      wdata_q  <= wdata_d;
      pend_q   <= pend_d;
      wp_blk_q <= wp_blk_d;
      mack_q   <= mack_d;
      upper_q  <= upper_d;
      timer_q  <= timer_d;
      we_q     <= we_d;
      busy_q   <= busy_d;
      ready_q  <= ready_d;
      SDA_O    <= 1'b0;
    end
  end

  assign SDA_OE = oe_q;
  assign BUSY   = busy_q;
  assign READY  = ready_q;
endmodule // eei_top
`default_nettype wire

//--- eei_consts.svh
// constants of the two-wire serial memory slave
`ifndef EEI_CONSTS_SVH
`define EEI_CONSTS_SVH

`define EEI_REF_CLK_KHZ   40000
`define EEI_T_WR_MS       5
`define EEI_T_PU_MS       1
`define EEI_WR_CYCLES     (`EEI_T_WR_MS * `EEI_REF_CLK_KHZ)
`define EEI_PU_CYCLES     (`EEI_T_PU_MS * `EEI_REF_CLK_KHZ)
`define EEI_TYPE_CODE     4'ha
`define EEI_TYPE_MSB      7
`define EEI_TYPE_LSB      4
`define EEI_SEL_MSB       3
`define EEI_SEL_LSB       1
`define EEI_RW_POS        0
`define EEI_BYTE_BITS     4'h8
`define EEI_ERASED_BYTE   8'hff
`define EEI_ARR_BITS_DEF  0
`define EEI_MAX_ARR_BITS  3

`endif

//--- eei_pkg.sv
// types of the two-wire serial memory slave
`default_nettype none
package eei_pkg;

  typedef enum logic [3:0] {
    ST_PWRUP,
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WADDR,
    ST_WDATA,
    ST_TX,
    ST_RXACK,
    ST_IGNORE,
    ST_BUSY
  } eei_state_t;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic       pg;
    logic [2:0] sel;
  } eei_pins_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } eei_bus_ev_t;

endpackage
`default_nettype wire

//--- eei_sync.sv
// two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module eei_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;

  always_comb begin
    meta_d = d;
  end

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    q      <= meta_q;
  end
endmodule // eei_sync
`default_nettype wire

//--- eei_mem.sv
// flip-flop byte array with one write and one read port
`timescale 1ns/1ps
`include "eei_consts.svh"
`default_nettype none
module eei_mem #(
  parameter int unsigned AW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [7:0]    rdata
);
  localparam int unsigned DEPTH = 1 << AW;

  logic [7:0] mem_q [DEPTH];
  logic [7:0] mem_d [DEPTH];

  always_comb begin
    mem_d = mem_q;
    if (we) begin
      mem_d[waddr] = wdata;
    end
    rdata = mem_q[raddr];
  end

  // reset only restores the erased delivery state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= `EEI_ERASED_BYTE;
      end
    end else begin
      mem_q <= mem_d;
    end
  end
endmodule // eei_mem
`default_nettype wire

//--- eei_top_asserts.sv
// checker watching the serial memory slave top ports
`timescale 1ns/1ps
`default_nettype none
module eei_top_asserts
  import eei_pkg::*;
#(
  parameter int unsigned ARR_BITS  = 0,
  parameter int unsigned WR_CYCLES = 200,
  parameter int unsigned PU_CYCLES = 50
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic SELECT_PIN_BIT0,
  input wire logic SELECT_PIN_BIT1,
  input wire logic SELECT_PIN_BIT2,
  input wire logic WRITE_PROTECT,
  input wire logic POWER_GOOD,
  input wire logic BUSY,
  input wire logic READY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  int unsigned busy_n_q;
  int unsigned busy_n_d;
  int unsigned rdy_n_q;
  int unsigned rdy_n_d;
  // power-up count restarts while power is bad
  always_comb begin
    busy_n_d = BUSY ? busy_n_q + 1 : 0;
    rdy_n_d  = (POWER_GOOD && !READY) ? rdy_n_q + 1 : 0;
  end
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      busy_n_q <= 0;
      rdy_n_q  <= 0;
    end else begin
      busy_n_q <= busy_n_d;
      rdy_n_q  <= rdy_n_d;
    end
  end
  oe_edge_a: assert property ($changed(SDA_OE) |-> !SCL)
    else $error("data drive changed while clock high");
  od_low_a: assert property (SDA_OE |-> !SDA_O)
    else $error("data output drives high");
  busy_quiet_a: assert property (BUSY |-> !SDA_OE)
    else $error("data driven during write cycle");
  busy_len_a: assert property ($fell(BUSY) |-> busy_n_q == WR_CYCLES)
    else $error("write cycle length wrong");
  stop_commit_a: assert property ($rose(BUSY) |->
    SCL && SDA_I && !$past(SDA_I, 10))
    else $error("write cycle began without stop");
  ready_time_a: assert property ($rose(READY) |->
    rdy_n_q inside {[PU_CYCLES:PU_CYCLES + 6]})
    else $error("ready time wrong");
  pg_drop_a: assert property (!POWER_GOOD |-> ##[1:4] !READY)
    else $error("ready kept after power drop");
  rst_quiet_a: assert property ($rose(RST_N) |->
    !SDA_OE && !BUSY && !READY)
    else $error("outputs active after reset");
endmodule // eei_top_asserts
`default_nettype wire

//--- eei_master.sv
// bus master model for the serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module eei_master (
  output var  logic scl,
  output var  logic sda_m,
  input  wire logic sda
);
  localparam int Q = 160;
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  // data moves only while clock low; long low suits slave latency
  task automatic bit_io(input logic b, output logic r);
    #(2*Q) sda_m = b;
    #(7*Q) scl = 1'b1;
    #(3*Q) r = sda;
    #(2*Q) scl = 1'b0;
  endtask
  task automatic start_c;
    #(2*Q) sda_m = 1'b1;
    #(2*Q) scl = 1'b1;
    #(4*Q) sda_m = 1'b0;
    #(4*Q) scl = 1'b0;
  endtask
  task automatic stop_c;
    #(2*Q) sda_m = 1'b0;
    #(7*Q) scl = 1'b1;
    #(4*Q) sda_m = 1'b1;
    #(8*Q);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mack, a);
    ack = ~a;
  endtask
endmodule // eei_master
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int WRC = 2000;
  localparam int PUC = 50;
  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic       wp      = 1'b0;
  logic       pg      = 1'b1;
  logic [2:0] sel     = 3'h0;
  logic       scl;
  logic       sda_m;
  logic       sda_o;
  logic       sda_oe;
  logic       busy;
  logic       ready;
  logic       r_bit;
  wire        sda;
  int         failures = 0;
  int         n_tests  = 0;
  // pull-up: low only when someone pulls
  assign sda = sda_m & ~(sda_oe & ~sda_o);
  always #12.5 ref_clk = ~ref_clk;
  eei_master m (.scl(scl), .sda_m(sda_m), .sda(sda));
  eei_top #(.ARR_BITS(0), .WR_CYCLES(WRC), .PU_CYCLES(PUC)) dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .SCL(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .SELECT_PIN_BIT0(sel[0]),
    .SELECT_PIN_BIT1(sel[1]), .SELECT_PIN_BIT2(sel[2]),
    .WRITE_PROTECT(wp), .POWER_GOOD(pg), .BUSY(busy), .READY(ready));
  task automatic check(input string w, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wt(input bit b, input logic v, input int n,
                    input string w);
    int k;
    k = 0;
    while (((b ? busy : ready) !== v) && k < n) begin
      @(posedge ref_clk);
      k++;
    end
    // step off the edge so the master never moves a pin on it
    #1;
    check(w, b ? busy : ready, v);
  endtask
  task automatic wr(input logic [7:0] b, input logic ea, input string w);
    logic [7:0] rx;
    logic       ack;
    m.xfer(b, 1'b1, rx, ack);
    check(w, ack, ea);
  endtask
  task automatic rd(input logic mack, input logic [7:0] ed,
                    input string w);
    logic [7:0] rx;
    logic       ack;
    m.xfer(8'hff, mack, rx, ack);
    check(w, rx, ed);
  endtask
  // dummy write sets the pointer, then two bytes are read
  task automatic peek(input logic [7:0] a, input logic [7:0] e0,
                      input logic [7:0] e1);
    m.start_c;
    wr(8'ha0, 1'b1, "dummy");
    wr(a, 1'b1, "pointer");
    m.start_c;
    wr(8'ha1, 1'b1, "restart");
    rd(1'b0, e0, "first");
    rd(1'b1, e1, "second");
    m.stop_c;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    check("rst oe", sda_oe, 1'b0);
    check("rst ready", ready, 1'b0);
    wt(0, 1'b1, PUC + 8, "ready");
    m.start_c;
    wr(8'ha1, 1'b1, "addr rd");
    rd(1'b1, 8'hff, "erased");
    m.stop_c;
    m.start_c;
    wr(8'ha0, 1'b1, "addr wr");
    wr(8'h10, 1'b1, "byte addr");
    wr(8'h5a, 1'b1, "data");
    m.stop_c;
    check("busy", busy, 1'b1);
    m.start_c;
    wr(8'ha0, 1'b0, "busy poll");
    m.stop_c;
    wt(1, 1'b0, WRC, "busy end");
    peek(8'h0f, 8'hff, 8'h5a);
    m.start_c;
    wr(8'ha1, 1'b1, "cur rd");
    rd(1'b1, 8'hff, "advance");
    m.stop_c;
    @(posedge ref_clk) wp <= 1'b1;
    #1;
    m.start_c;
    wr(8'ha0, 1'b1, "wp addr");
    wr(8'h20, 1'b1, "wp ptr");
    wr(8'h33, 1'b0, "wp data");
    m.stop_c;
    @(posedge ref_clk) wp <= 1'b0;
    #1;
    check("wp busy", busy, 1'b0);
    peek(8'h20, 8'hff, 8'hff);
    m.start_c;
    wr(8'hb0, 1'b0, "type miss");
    wr(8'ha0, 1'b0, "stay deaf");
    m.stop_c;
    @(posedge ref_clk) sel <= 3'h5;
    #1;
    m.start_c;
    wr(8'ha0, 1'b0, "sel miss");
    m.stop_c;
    m.start_c;
    wr(8'haa, 1'b1, "sel hit");
    m.stop_c;
    wr(8'haa, 1'b0, "no start");
    m.stop_c;
    m.start_c;
    for (int i = 0; i < 4; i++) m.bit_io(!i[0], r_bit);
    m.stop_c;
    m.start_c;
    for (int i = 0; i < 4; i++) m.bit_io(!i[0], r_bit);
    m.start_c;
    wr(8'hab, 1'b1, "after abort");
    rd(1'b1, 8'hff, "abort rd");
    m.stop_c;
    @(posedge ref_clk) pg <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check("pg drop", ready, 1'b0);
    pg <= 1'b1;
    wt(0, 1'b1, PUC + 10, "pg ready");
    conclude;
  end
  // hang guard well beyond the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    conclude;
  end
endmodule // tb_top
bind eei_top eei_top_asserts #(
  .ARR_BITS(ARR_BITS), .WR_CYCLES(WR_CYCLES), .PU_CYCLES(PU_CYCLES)
) u_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .SCL(SCL), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SELECT_PIN_BIT0(SELECT_PIN_BIT0),
  .SELECT_PIN_BIT1(SELECT_PIN_BIT1), .SELECT_PIN_BIT2(SELECT_PIN_BIT2),
  .WRITE_PROTECT(WRITE_PROTECT), .POWER_GOOD(POWER_GOOD),
  .BUSY(BUSY), .READY(READY));
`default_nettype wire
